// ==== tcr_bank.sv ====
// register bank and probe selector of the dual tuner
//
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/1ps
module tcr_bank
   import tcr_pkg::*;
(
   input wire logic mclk_in, // 25 MHz device clock
   input wire logic rst_in, // async reset, active high
   input wire logic [ADDR_W-1:0] avs_address_in, // byte address
   input wire logic avs_read_in, // read request
   input wire logic avs_write_in, // write request
   input wire logic [3:0] avs_byteenable_in, // byte lanes
   input wire logic [DATA_W-1:0] avs_writedata_in, // write data
   output logic [DATA_W-1:0] avs_readdata_out, // read data
   output logic avs_waitrequest_out, // stall, low for one answer cycle
   input wire logic [IDX_W-1:0] coef_idx_in, // datapath byte index, 0 = location 128
   output logic [7:0] coef_byte_out, // datapath byte, one cycle later
   input wire logic [PROBE_W-1:0] first_fir_stage_out_ai_in, // first filter output A in-phase
   input wire logic [PROBE_W-1:0] first_fir_stage_out_aq_in, // first filter output A quadrature
   input wire logic [PROBE_W-1:0] first_fir_stage_out_bi_in, // first filter output B in-phase
   input wire logic [PROBE_W-1:0] first_fir_stage_out_bq_in, // first filter output B quadrature
   input wire logic [PROBE_W-1:0] first_fir_stage_in_ai_in, // first filter input A in-phase
   input wire logic [PROBE_W-1:0] first_fir_stage_in_aq_in, // first filter input A quadrature
   input wire logic [PROBE_W-1:0] first_fir_stage_in_bi_in, // first filter input B in-phase
   input wire logic [PROBE_W-1:0] first_fir_stage_in_bq_in, // first filter input B quadrature
   input wire logic [NCO_W-1:0] nco_a_sin_in, // oscillator A sine
   input wire logic [NCO_W-1:0] nco_a_cos_in, // oscillator A cosine
   input wire logic [NCO_W-1:0] nco_b_sin_in, // oscillator B sine
   input wire logic [NCO_W-1:0] nco_b_cos_in, // oscillator B cosine
   input wire logic [MIX_W-1:0] mix_ai_in, // rounded mixer A in-phase
   input wire logic [MIX_W-1:0] mix_aq_in, // rounded mixer A quadrature
   input wire logic [MIX_W-1:0] mix_bi_in, // rounded mixer B in-phase
   input wire logic [MIX_W-1:0] mix_bq_in, // rounded mixer B quadrature
   input wire logic [CIC_W-1:0] cic_a_in, // gain-loop CIC output A
   input wire logic [CIC_W-1:0] cic_b_in, // gain-loop CIC output B
   output logic dither_enable_chan_a_out, // oscillator dither A enable
   output logic dither_enable_chan_b_out, // oscillator dither B enable
   output logic [PROBE_W-1:0] probe_out // debug probe value
);
   tcr_mem_if mem_if ();
   tcr_state_t state_reg;
   logic [7:0] ctrl_reg;
   logic [LOC_W-1:0] loc;
   logic lane0;
   logic [4:0] sel;
   logic [PROBE_W-1:0] probe_next;
   logic bus_take;
   logic ctrl_wr;
   logic mem_rd;

   assign loc = avs_address_in[ADDR_W-1:2];
   assign lane0 = avs_byteenable_in[0];
   assign sel = ctrl_reg[CTRL_SEL_MSB:CTRL_SEL_LSB];

   // =================================================================
   // decode of the access being taken or answered
   assign bus_take = (state_reg == ST_IDLE) && (avs_read_in || avs_write_in);
   assign ctrl_wr = (state_reg == ST_FETCH) && avs_write_in && lane0 && (loc == LOC_CTRL);
   assign mem_rd = (state_reg == ST_FETCH) && avs_read_in && tcr_in_mem(loc);

   tcr_mem u_mem (
      .mclk_in(mclk_in),
      .rst_in(rst_in),
      .mem_if(mem_if)
   );

   // =================================================================
   // memory port wiring
   assign mem_if.rd_idx = tcr_mem_idx(loc);
   assign mem_if.wr_idx = tcr_mem_idx(loc);
   assign mem_if.wr_data = avs_writedata_in[7:0];
   assign mem_if.wr_en = (state_reg == ST_FETCH) && avs_write_in && lane0
      && tcr_in_mem(loc);
   assign mem_if.dp_idx = coef_idx_in;
   assign coef_byte_out = mem_if.dp_data;

   // =================================================================
   // bus handshake: take, fetch, answer for one cycle
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         state_reg <= ST_IDLE;
      end else begin
         unique case (state_reg)
            ST_IDLE: begin
               if (bus_take) begin
                  state_reg <= ST_FETCH;
               end
            end
            ST_FETCH: begin
               state_reg <= ST_ACK;
            end
            ST_ACK: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // from a flop, so every answer comes on the third edge after the take
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         avs_waitrequest_out <= 1'b1;
      end else begin
         avs_waitrequest_out <= (state_reg != ST_FETCH);
      end
   end

   // =================================================================
   // read data, unmapped locations read as zero
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         avs_readdata_out <= '0;
      end else if (state_reg == ST_FETCH && avs_read_in) begin
         if (loc == LOC_CTRL) begin
            avs_readdata_out <= {24'h000000, ctrl_reg};
         end else if (tcr_in_mem(loc)) begin
            avs_readdata_out <= {24'h000000, mem_if.rd_data};
         end else begin
            avs_readdata_out <= '0;
         end
      end
   end

   // =================================================================
   // control location: probe gate, selector, dither enables
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         ctrl_reg <= CTRL_RESET;
      end else if (ctrl_wr) begin
         ctrl_reg <= avs_writedata_in[7:0];
      end
   end

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         dither_enable_chan_a_out <= CTRL_RESET[CTRL_DITHER_A_BIT];
         dither_enable_chan_b_out <= CTRL_RESET[CTRL_DITHER_B_BIT];
      end else begin
         dither_enable_chan_a_out <= ctrl_reg[CTRL_DITHER_A_BIT];
         dither_enable_chan_b_out <= ctrl_reg[CTRL_DITHER_B_BIT];
      end
   end

   // =================================================================
   // probe selection
   always_comb begin
      probe_next = '0;
      if (!ctrl_reg[CTRL_PROBE_EN_BIT]) begin
         probe_next = '0;
      end else if (sel >= SEL_CIC_BASE) begin
         probe_next = {cic_a_in, cic_b_in, 2'b00};
      end else begin
         unique case (sel[3:0])
            4'h0: probe_next = first_fir_stage_out_ai_in;
            4'h1: probe_next = first_fir_stage_out_aq_in;
            4'h2: probe_next = first_fir_stage_out_bi_in;
            4'h3: probe_next = first_fir_stage_out_bq_in;
            4'h4: probe_next = first_fir_stage_in_ai_in;
            4'h5: probe_next = first_fir_stage_in_aq_in;
            4'h6: probe_next = first_fir_stage_in_bi_in;
            4'h7: probe_next = first_fir_stage_in_bq_in;
            4'h8: probe_next = {nco_a_sin_in, 3'b000};
            4'h9: probe_next = {nco_a_cos_in, 3'b000};
            4'hA: probe_next = {nco_b_sin_in, 3'b000};
            4'hB: probe_next = {nco_b_cos_in, 3'b000};
            4'hC: probe_next = {mix_ai_in, 5'h00};
            4'hD: probe_next = {mix_aq_in, 5'h00};
            4'hE: probe_next = {mix_bi_in, 5'h00};
            4'hF: probe_next = {mix_bq_in, 5'h00};
         endcase
      end
   end

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         probe_out <= '0;
      end else begin
         probe_out <= probe_next;
      end
   end

   // =================================================================
   // checks
   ctrl_write_a: assert property (@(posedge mclk_in) disable iff (rst_in)
      (state_reg == ST_FETCH && avs_write_in && lane0 && loc == LOC_CTRL)
      |=> ctrl_reg == $past(avs_writedata_in[7:0]))
      else $error("control location did not take written byte");

   dither_follow_a: assert property (@(posedge mclk_in) disable iff (rst_in)
      ##1 (dither_enable_chan_a_out == $past(ctrl_reg[CTRL_DITHER_A_BIT])
      && dither_enable_chan_b_out == $past(ctrl_reg[CTRL_DITHER_B_BIT])))
      else $error("dither enables do not follow control bits");

   probe_gate_a: assert property (@(posedge mclk_in) disable iff (rst_in)
      !ctrl_reg[CTRL_PROBE_EN_BIT] |=> probe_out == '0)
      else $error("probe not quiet while gated");

   probe_fir_in_a: assert property (@(posedge mclk_in) disable iff (rst_in)
      (ctrl_reg[CTRL_PROBE_EN_BIT] && sel == SEL_FIRST_FIR_STAGE_IN)
      |=> probe_out == $past(first_fir_stage_in_ai_in))
      else $error("probe code 4 wrong");

   probe_nco_a: assert property (@(posedge mclk_in) disable iff (rst_in)
      (ctrl_reg[CTRL_PROBE_EN_BIT] && sel == SEL_NCO_BASE)
      |=> probe_out == {$past(nco_a_sin_in), 3'b000})
      else $error("probe oscillator code wrong");

   probe_mix_a: assert property (@(posedge mclk_in) disable iff (rst_in)
      (ctrl_reg[CTRL_PROBE_EN_BIT] && sel >= SEL_MIX_BASE && sel < SEL_CIC_BASE)
      |=> probe_out[4:0] == 5'h00)
      else $error("probe mixer low bits not zero");

   probe_cic_a: assert property (@(posedge mclk_in) disable iff (rst_in)
      (ctrl_reg[CTRL_PROBE_EN_BIT] && sel >= SEL_CIC_BASE)
      |=> probe_out == {$past(cic_a_in), $past(cic_b_in), 2'b00})
      else $error("probe CIC packing wrong");

   ctrl_read_a: assert property (@(posedge mclk_in) disable iff (rst_in)
      (state_reg == ST_FETCH && avs_read_in && loc == LOC_CTRL)
      |=> (avs_readdata_out == {24'h000000, $past(ctrl_reg)}) && !avs_waitrequest_out)
      else $error("control readback wrong");

   ack_single_a: assert property (@(posedge mclk_in) disable iff (rst_in)
      $fell(avs_waitrequest_out) |=> avs_waitrequest_out)
      else $error("waitrequest low longer than one cycle");

   mem_write_a: assert property (@(posedge mclk_in) disable iff (rst_in)
      (state_reg == ST_IDLE && avs_write_in && lane0 && tcr_in_mem(loc))
      |=> mem_if.wr_en ##2 (state_reg == ST_IDLE))
      else $error("memory write not issued");

   // =================================================================
   // handshake, readback, control hold and dither B checks
   answer_time_a: assert property (@(posedge mclk_in) disable iff (rst_in)
      bus_take
      |=> ##1 !avs_waitrequest_out)
      else $error("request not answered on the third edge");

   idle_wait_a: assert property (@(posedge mclk_in) disable iff (rst_in)
      state_reg == ST_IDLE
      |-> avs_waitrequest_out)
      else $error("waitrequest low while idle");

   state_order_a: assert property (@(posedge mclk_in) disable iff (rst_in)
      state_reg == ST_FETCH
      |=> (state_reg == ST_ACK) ##1 (state_reg == ST_IDLE))
      else $error("handshake states out of order");

   read_upper_a: assert property (@(posedge mclk_in) disable iff (rst_in)
      !avs_waitrequest_out
      |-> avs_readdata_out[DATA_W-1:8] == '0)
      else $error("read data upper bytes not zero");

   unmapped_read_a: assert property (@(posedge mclk_in) disable iff (rst_in)
      (state_reg == ST_FETCH && avs_read_in && loc != LOC_CTRL && !tcr_in_mem(loc))
      |=> avs_readdata_out == '0)
      else $error("unmapped location read not zero");

   mem_read_a: assert property (@(posedge mclk_in) disable iff (rst_in)
      mem_rd
      |=> avs_readdata_out == {24'h000000, $past(mem_if.rd_data)})
      else $error("memory readback not passed on");

   ctrl_hold_a: assert property (@(posedge mclk_in) disable iff (rst_in)
      !ctrl_wr
      |=> $stable(ctrl_reg))
      else $error("control location changed without a write");

   dither_end_a: assert property (@(posedge mclk_in) disable iff (rst_in)
      ctrl_wr
      |=> ##1 dither_enable_chan_b_out == $past(avs_writedata_in[CTRL_DITHER_B_BIT], 2))
      else $error("dither B enable does not follow written bit");

   // =================================================================
   // further probe routing checks
   probe_fir_out_a: assert property (@(posedge mclk_in) disable iff (rst_in)
      (ctrl_reg[CTRL_PROBE_EN_BIT] && sel == 5'h00)
      |=> probe_out == $past(first_fir_stage_out_ai_in))
      else $error("probe code 0 wrong");

   probe_last_in_a: assert property (@(posedge mclk_in) disable iff (rst_in)
      (ctrl_reg[CTRL_PROBE_EN_BIT] && sel == SEL_FIRST_FIR_STAGE_IN + 5'h03)
      |=> probe_out == $past(first_fir_stage_in_bq_in))
      else $error("probe code 7 wrong");

   probe_cos_a: assert property (@(posedge mclk_in) disable iff (rst_in)
      (ctrl_reg[CTRL_PROBE_EN_BIT] && sel == SEL_NCO_BASE + 5'h03)
      |=> probe_out == {$past(nco_b_cos_in), 3'b000})
      else $error("probe code 11 wrong");

   probe_mixer_a: assert property (@(posedge mclk_in) disable iff (rst_in)
      (ctrl_reg[CTRL_PROBE_EN_BIT] && sel == SEL_MIX_BASE + 5'h03)
      |=> probe_out == {$past(mix_bq_in), 5'h00})
      else $error("probe code 15 wrong");
endmodule

// ==== tcr_mem.sv ====
// byte memory for gain table and both filter coefficient sets
`timescale 1ns/1ps
module tcr_mem
   import tcr_pkg::*;
(
   input wire logic mclk_in, // device clock
   input wire logic rst_in, // async reset, active high
   tcr_mem_if.mem mem_if // write port and two registered read ports
);
   logic [7:0] store_reg [MEM_DEPTH];

   // =================================================================
   // storage, all bytes clear at reset
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         for (int i = 0; i < MEM_DEPTH; i++) begin
            store_reg[i] <= MEM_RESET;
         end
      end else if (mem_if.wr_en && (int'(mem_if.wr_idx) < MEM_DEPTH)) begin
         store_reg[mem_if.wr_idx] <= mem_if.wr_data;
      end
   end

   // =================================================================
   // software read port
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         mem_if.rd_data <= MEM_RESET;
      end else if (int'(mem_if.rd_idx) < MEM_DEPTH) begin
         mem_if.rd_data <= store_reg[mem_if.rd_idx];
      end else begin
         mem_if.rd_data <= MEM_RESET;
      end
   end

   // =================================================================
   // datapath read port, one copy serves both channels
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         mem_if.dp_data <= MEM_RESET;
      end else if (int'(mem_if.dp_idx) < MEM_DEPTH) begin
         mem_if.dp_data <= store_reg[mem_if.dp_idx];
      end else begin
         mem_if.dp_data <= MEM_RESET;
      end
   end
endmodule

// ==== tcr_mem_if.sv ====
// signals between the register front end and the coefficient memory
`timescale 1ns/1ps
interface tcr_mem_if;
   import tcr_pkg::*;
   logic wr_en;
   logic [IDX_W-1:0] wr_idx;
   logic [7:0] wr_data;
   logic [IDX_W-1:0] rd_idx;
   logic [7:0] rd_data;
   logic [IDX_W-1:0] dp_idx;
   logic [7:0] dp_data;
   modport ctrl (output wr_en, wr_idx, wr_data, rd_idx, dp_idx, input rd_data, dp_data);
   modport mem (input wr_en, wr_idx, wr_data, rd_idx, dp_idx, output rd_data, dp_data);
endinterface

// ==== tcr_pkg.sv ====
// constants, types and the field map of the tuner configuration bank
// =====================================================================
package tcr_pkg;
   // =================================================================
   // bus geometry
   localparam int ADDR_W = 10;
   localparam int DATA_W = 32;
   localparam int LOC_W = 8;
   localparam int IDX_W = 7;
   // =================================================================
   // location map (locations are word indices, byte address = 4 * location)
   localparam logic [LOC_W-1:0] LOC_CTRL = 8'h1F;
   localparam logic [LOC_W-1:0] LOC_GAIN_FIRST = 8'h80;
   localparam logic [LOC_W-1:0] LOC_GAIN_LAST = 8'h9F;
   localparam logic [LOC_W-1:0] LOC_FIRST_FIR_STAGE_LO = 8'hA0;
   localparam logic [LOC_W-1:0] LOC_FIRST_FIR_STAGE_HI = 8'hB5;
   localparam logic [LOC_W-1:0] LOC_SECOND_FIR_STAGE_LO = 8'hB6;
   localparam logic [LOC_W-1:0] LOC_SECOND_FIR_STAGE_HI = 8'hF5;
   localparam logic [LOC_W-1:0] LOC_MEM_BASE = LOC_GAIN_FIRST;
   localparam logic [LOC_W-1:0] LOC_MEM_LAST = LOC_SECOND_FIR_STAGE_HI;
   localparam int MEM_DEPTH = 118;
   localparam logic [7:0] MEM_RESET = 8'h00;
   // =================================================================
   // control location fields
   localparam int CTRL_PROBE_EN_BIT = 0;
   localparam int CTRL_SEL_LSB = 1;
   localparam int CTRL_SEL_MSB = 5;
   localparam int CTRL_DITHER_A_BIT = 6;
   localparam int CTRL_DITHER_B_BIT = 7;
   localparam logic [7:0] CTRL_RESET = 8'hC0;
   // =================================================================
   // probe routing
   localparam int PROBE_W = 20;
   localparam int NCO_W = 17;
   localparam int MIX_W = 15;
   localparam int CIC_W = 9;
   localparam logic [4:0] SEL_FIRST_FIR_STAGE_IN = 5'h04;
   localparam logic [4:0] SEL_NCO_BASE = 5'h08;
   localparam logic [4:0] SEL_MIX_BASE = 5'h0C;
   localparam logic [4:0] SEL_CIC_BASE = 5'h10;

   typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_ACK} tcr_state_t;

   function automatic logic tcr_in_mem(input logic [LOC_W-1:0] loc);
      return (loc >= LOC_MEM_BASE) && (loc <= LOC_MEM_LAST);
   endfunction

   function automatic logic [IDX_W-1:0] tcr_mem_idx(input logic [LOC_W-1:0] loc);
      logic [LOC_W-1:0] diff;
      diff = loc - LOC_MEM_BASE;
      return diff[IDX_W-1:0];
   endfunction
endpackage

// ==== test_tuner_coeff_ram_and_probe_select.sv ====
// self-checking testbench of the tuner configuration bank
`timescale 1ns/1ps
module test_tuner_coeff_ram_and_probe_select;
   import tcr_pkg::*;
   // =================================================================
   // stimulus and observed signals
   logic mclk_in;
   logic rst_in;
   logic [ADDR_W-1:0] avs_address;
   logic avs_read;
   logic avs_write;
   logic [3:0] avs_be;
   logic [DATA_W-1:0] avs_wdata;
   logic [DATA_W-1:0] avs_readdata;
   logic avs_waitrequest;
   logic [IDX_W-1:0] coef_idx;
   logic [7:0] coef_byte;
   logic [PROBE_W-1:0] f1o [4];
   logic [PROBE_W-1:0] f1i [4];
   logic [NCO_W-1:0] nco [4];
   logic [MIX_W-1:0] mix [4];
   logic [CIC_W-1:0] cic [2];
   logic dither_enable_chan_a;
   logic dither_enable_chan_b;
   logic [PROBE_W-1:0] probe;
   int n_mismatch;
   int compares;
   logic [7:0] locs [8] = '{8'h80, 8'h9F, 8'hA0, 8'hA1, 8'hB5, 8'hB6, 8'hB7, 8'hF5};
   logic [7:0] ctrls [4] = '{8'h40, 8'h80, 8'h00, 8'hC0};
   logic [31:0] r;

   tcr_bank i_dut (.mclk_in(mclk_in), .rst_in(rst_in), .avs_address_in(avs_address),
      .avs_read_in(avs_read), .avs_write_in(avs_write), .avs_byteenable_in(avs_be),
      .avs_writedata_in(avs_wdata), .avs_readdata_out(avs_readdata),
      .avs_waitrequest_out(avs_waitrequest), .coef_idx_in(coef_idx), .coef_byte_out(coef_byte),
      .first_fir_stage_out_ai_in(f1o[0]), .first_fir_stage_out_aq_in(f1o[1]),
      .first_fir_stage_out_bi_in(f1o[2]), .first_fir_stage_out_bq_in(f1o[3]),
      .first_fir_stage_in_ai_in(f1i[0]), .first_fir_stage_in_aq_in(f1i[1]),
      .first_fir_stage_in_bi_in(f1i[2]), .first_fir_stage_in_bq_in(f1i[3]),
      .nco_a_sin_in(nco[0]), .nco_a_cos_in(nco[1]), .nco_b_sin_in(nco[2]), .nco_b_cos_in(nco[3]),
      .mix_ai_in(mix[0]), .mix_aq_in(mix[1]), .mix_bi_in(mix[2]), .mix_bq_in(mix[3]),
      .cic_a_in(cic[0]), .cic_b_in(cic[1]), .dither_enable_chan_a_out(dither_enable_chan_a),
      .dither_enable_chan_b_out(dither_enable_chan_b), .probe_out(probe));

   always #20 mclk_in = ~mclk_in;

   // =================================================================
   // shared tasks
   task automatic final_report;
      if (n_mismatch == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask

   // one bus transfer: request held until waitrequest is sampled low
   task automatic bus(input logic wr_en, input logic [7:0] loc, input logic [7:0] wd,
      input logic [3:0] be, output logic [31:0] rd);
      int n;
      n = 0;
      rd = 32'h00000000;
      @(posedge mclk_in);
      avs_address <= {loc, 2'h0};
      avs_write <= wr_en;
      avs_read <= ~wr_en;
      avs_be <= be;
      avs_wdata <= {24'h000000, wd};
      // waitrequest and read data are taken at the rising edge, before the slave updates them
      do begin
         @(posedge mclk_in);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 100);
      if (avs_waitrequest !== 1'b0) begin
         chk("waitrequest", 32'h00000000, {31'h00000000, avs_waitrequest});
         final_report;
      end else begin
         rd = avs_readdata;
         avs_read <= 1'b0;
         avs_write <= 1'b0;
      end
   endtask

   task automatic wr(input logic [7:0] loc, input logic [7:0] d);
      logic [31:0] x;
      bus(1'b1, loc, d, 4'hF, x);
   endtask

   task automatic rd_chk(input logic [7:0] loc, input logic [7:0] exp);
      logic [31:0] x;
      bus(1'b0, loc, 8'h00, 4'hF, x);
      chk("readdata", {24'h000000, exp}, x);
   endtask

   task automatic dp_chk(input logic [IDX_W-1:0] idx, input logic [7:0] exp);
      @(posedge mclk_in);
      coef_idx <= idx;
      repeat (2) @(posedge mclk_in);
      @(negedge mclk_in);
      chk("coef_byte", {24'h000000, exp}, {24'h000000, coef_byte});
   endtask

   function automatic logic [PROBE_W-1:0] exp_probe(input logic [4:0] code);
      case (code) inside
         [5'h00:5'h03]: return f1o[code[1:0]];
         [5'h04:5'h07]: return f1i[code[1:0]];
         [5'h08:5'h0B]: return {nco[code[1:0]], 3'h0};
         [5'h0C:5'h0F]: return {mix[code[1:0]], 5'h00};
         default: return {cic[0], cic[1], 2'h0};
      endcase
   endfunction

   // =================================================================
   // watchdog
   initial begin
      repeat (20000) @(posedge mclk_in);
      n_mismatch++;
      final_report;
   end

   // =================================================================
   // tests
   initial begin
      mclk_in = 1'b0;
      rst_in = 1'b1;
      avs_address = 10'h000;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_be = 4'h0;
      avs_wdata = 32'h00000000;
      coef_idx = 7'h00;
      f1o = '{20'hA1234, 20'hB2345, 20'hC3456, 20'hD4567};
      f1i = '{20'h1E5A7, 20'h2D6B8, 20'h3C7C9, 20'h4B8DA};
      nco = '{17'h1A5A5, 17'h0C3C3, 17'h15555, 17'h0F0F1};
      mix = '{15'h7123, 15'h2B4C, 15'h5D6E, 15'h1F80};
      cic = '{9'h1A5, 9'h05A};
      repeat (5) @(posedge mclk_in);
      rst_in <= 1'b0;
      @(negedge mclk_in);
      chk("dither_a", 32'h00000001, {31'h00000000, dither_enable_chan_a});
      chk("dither_b", 32'h00000001, {31'h00000000, dither_enable_chan_b});
      chk("probe", 32'h00000000, {12'h000, probe});
      rd_chk(8'h1F, 8'hC0);
      foreach (locs[i]) rd_chk(locs[i], 8'h00);
      foreach (locs[i]) wr(locs[i], locs[i] ^ 8'h5A);
      foreach (locs[i]) rd_chk(locs[i], locs[i] ^ 8'h5A);
      dp_chk(7'h00, 8'hDA);
      dp_chk(7'h20, 8'hFA);
      dp_chk(7'h75, 8'hAF);
      // one first-filter coefficient, low byte at the lower location
      wr(8'hA2, 8'hEF);
      wr(8'hA3, 8'hBE);
      dp_chk(7'h22, 8'hEF);
      dp_chk(7'h23, 8'hBE);
      rd_chk(8'hA3, 8'hBE);
      // unmapped locations and disabled byte lane leave storage alone
      wr(8'h1E, 8'hFF);
      wr(8'hF6, 8'hFF);
      rd_chk(8'h1E, 8'h00);
      rd_chk(8'hF6, 8'h00);
      bus(1'b1, 8'h80, 8'h11, 4'h0, r);
      rd_chk(8'h80, 8'hDA);
      foreach (ctrls[i]) begin
         wr(8'h1F, ctrls[i]);
         @(negedge mclk_in);
         chk("dither_a", {31'h00000000, ctrls[i][6]}, {31'h00000000, dither_enable_chan_a});
         chk("dither_b", {31'h00000000, ctrls[i][7]}, {31'h00000000, dither_enable_chan_b});
         rd_chk(8'h1F, ctrls[i]);
      end
      for (int c = 0; c < 32; c++) begin
         wr(8'h1F, {2'h3, c[4:0], 1'b1});
         repeat (2) @(negedge mclk_in);
         chk("probe", {12'h000, exp_probe(c[4:0])}, {12'h000, probe});
      end
      wr(8'h1F, 8'hC6);
      repeat (2) @(negedge mclk_in);
      chk("probe", 32'h00000000, {12'h000, probe});
      rd_chk(8'h1F, 8'hC6);
      // second reset in mid-run restores every reset value
      @(posedge mclk_in);
      rst_in <= 1'b1;
      repeat (2) @(posedge mclk_in);
      rst_in <= 1'b0;
      rd_chk(8'h80, 8'h00);
      rd_chk(8'hB6, 8'h00);
      rd_chk(8'h1F, 8'hC0);
      final_report;
   end
endmodule
